// >>> common/ofd_pkg.sv
// Purpose: Shared constants and types of the opcode field decoder.
// Assumes: 16-bit instruction words, 32-bit APB data, 12-bit APB byte addresses.
// Notes:   Register offsets are byte addresses, one aligned word each.
package ofd_pkg;

	// ====================================================================
	// Register map.
	localparam logic [11:0] OFS_BANK   = 12'h000;
	localparam logic [11:0] OFS_TPTR   = 12'h004;
	localparam logic [11:0] OFS_ADDR   = 12'h008;
	localparam logic [11:0] OFS_LIT    = 12'h00C;
	localparam logic [11:0] OFS_TARGET = 12'h010;
	localparam logic [11:0] OFS_MOVE   = 12'h014;
	localparam logic [11:0] OFS_OFFS   = 12'h018;
	localparam logic [11:0] OFS_STAT   = 12'h01C;

	// ====================================================================
	// Readback field positions (least significant bit of each field).
	localparam int RB_ADDR_LO  = 0;
	localparam int RB_BIT_LO   = 12;
	localparam int RB_DEST     = 15;
	localparam int RB_PSEL_LO  = 16;
	localparam int RB_FAST     = 18;
	localparam int RB_MODE_LO  = 19;
	localparam int RB_NOP      = 21;
	localparam int RB_REL      = 22;
	localparam int RB_DST_LO   = 16;
	localparam int RB_DOFF_LO  = 8;

	// ====================================================================
	// Instruction word field positions.
	localparam int POS_ACC     = 8;
	localparam int POS_DEST    = 9;
	localparam int POS_BIT_LO  = 9;
	localparam int POS_PSEL_LO = 4;
	localparam int POS_FAST    = 0;
	localparam int POS_CALL_FAST = 8; // Call keeps its fast bit above the low literal byte.
	localparam int POS_STEP_LO = 0;
	localparam int POS_TAG_LO  = 12;
	localparam logic [3:0] SECOND_TAG = 4'hF;

	// ====================================================================
	// Reset values and access RAM split.
	localparam logic [3:0]  RST_BANK       = 4'h0;
	localparam logic [20:0] RST_TPTR       = 21'h000000;
	localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
	localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;

	// Instruction classes announced by the fetch unit.
	typedef enum logic [3:0] {
		CLS_BYTE   = 4'h0,
		CLS_BIT    = 4'h1,
		CLS_LIT    = 4'h2,
		CLS_LFSR   = 4'h3,
		CLS_MOVFF  = 4'h4,
		CLS_MOVSS  = 4'h5,
		CLS_TABLE  = 4'h6,
		CLS_CALL   = 4'h7,
		CLS_RETURN = 4'h8,
		CLS_GOTO   = 4'h9,
		CLS_BRA    = 4'hA,
		CLS_BCOND  = 4'hB
	} ofd_cls_t;

	// Table pointer step modes.
	typedef enum logic [1:0] {
		TS_NONE     = 2'h0,
		TS_POST_INC = 2'h1,
		TS_POST_DEC = 2'h2,
		TS_PRE_INC  = 2'h3
	} ofd_step_t;

	// Fetch sequencer states.
	typedef enum logic [1:0] {
		ST_FIRST  = 2'b01,
		ST_SECOND = 2'b10
	} ofd_state_t;

	// Decoded operand fields.
	typedef struct packed {
		logic [11:0] data_addr;
		logic [2:0]  bit_pos;
		logic        dest_file;
		logic [1:0]  ptr_select;
		logic [19:0] lit;
		logic [20:0] target;
		logic        target_rel;
		logic        fast;
		logic [11:0] src_addr;
		logic [11:0] dst_addr;
		logic [6:0]  src_off;
		logic [6:0]  dst_off;
		ofd_step_t   mode;
		logic        nop;
	} ofd_dec_t;

endpackage

// >>> common/ofd_fields_if.sv
// Purpose: Carries instruction words to the field unit and decoded fields back.
// Assumes: Purely combinational path inside one clock domain.
// Notes:   The sequencer drives words and class; the field unit drives dec.
`timescale 1ns/1ps
interface ofd_fields_if
	import ofd_pkg::*;
	();
	logic [15:0] word1;
	logic [15:0] word2;
	logic [3:0]  bank;
	ofd_cls_t    cls;
	ofd_dec_t    dec;

	modport req (output word1, word2, bank, cls, input dec);
	modport fld (input word1, word2, bank, cls, output dec);
endinterface

// >>> hw/ofd_field_unit.sv
// Purpose: Extracts operand fields from one or two instruction words.
// Assumes: Class comes from fetch; opcode bit patterns are not checked here.
// Notes:   Data address and bit position are formed from word 1 for every class; other fields only for their class.
`timescale 1ns/1ps
module ofd_field_unit
	import ofd_pkg::*;
(
	ofd_fields_if.fld f
);

	// ====================================================================
	// Field extraction.
	logic [7:0] f8;

	// Splits the words into fields and forms the data address and targets.
	always_comb begin
		f8 = f.word1[7:0];
		f.dec = '0;
		f.dec.bit_pos = f.word1[POS_BIT_LO +: 3];
		if (f.word1[POS_ACC]) begin
			f.dec.data_addr = {f.bank, f8};
		end else if (f8 < ACCESS_SPLIT) begin
			f.dec.data_addr = {ACCESS_LO_BANK, f8};
		end else begin
			f.dec.data_addr = {ACCESS_HI_BANK, f8};
		end
		case (f.cls)
			CLS_BYTE: begin
				f.dec.dest_file = f.word1[POS_DEST];
			end
			CLS_LIT: begin
				f.dec.lit = {12'h000, f8};
			end
			CLS_LFSR: begin
				f.dec.ptr_select = f.word1[POS_PSEL_LO +: 2];
				f.dec.lit = {8'h00, f.word1[3:0], f.word2[7:0]};
			end
			CLS_MOVFF: begin
				f.dec.src_addr = f.word1[11:0];
				f.dec.dst_addr = f.word2[11:0];
			end
			CLS_MOVSS: begin
				f.dec.src_off = f.word1[6:0];
				f.dec.dst_off = f.word2[6:0];
			end
			CLS_TABLE: begin
				f.dec.mode = ofd_step_t'(f.word1[POS_STEP_LO +: 2]);
			end
			CLS_RETURN: begin
				f.dec.fast = f.word1[POS_FAST];
			end
			CLS_CALL, CLS_GOTO: begin
				f.dec.fast = (f.cls == CLS_CALL) & f.word1[POS_CALL_FAST];
				f.dec.lit = {f.word2[11:0], f8};
				f.dec.target = {f.word2[11:0], f8, 1'b0};
			end
			CLS_BRA: begin
				f.dec.target = {{10{f.word1[10]}}, f.word1[10:0]};
				f.dec.target_rel = 1'b1;
			end
			CLS_BCOND: begin
				f.dec.target = {{13{f8[7]}}, f8};
				f.dec.target_rel = 1'b1;
			end
			default: begin
				f.dec.dest_file = 1'b0; // Bit class needs only address and position.
			end
		endcase
	end

endmodule

// >>> hw/ofd_table_ptr.sv
// Purpose: Holds the program table pointer and steps it on table accesses.
// Assumes: A software write and a step in the same cycle: the write wins.
// Notes:   Access address and strobe are registered with the step.
`timescale 1ns/1ps
module ofd_table_ptr
	import ofd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        wr_en,
	input  wire logic [20:0] wr_data,
	input  wire logic        step_en,
	input  wire ofd_step_t   mode,
	output logic      [20:0] ptr,
	output logic      [20:0] acc_addr,
	output logic             acc_strobe
);

	// ====================================================================
	// Pointer update.
	logic [20:0] ptr_q, ptr_d, acc_q, acc_d;
	logic        stb_q, stb_d;

	// Computes the access address and the pointer after the step.
	always_comb begin
		ptr_d = ptr_q;
		acc_d = acc_q;
		stb_d = step_en;
		if (step_en) begin
			acc_d = (mode == TS_PRE_INC) ? ptr_q + 21'h000001 : ptr_q;
			case (mode)
				TS_POST_INC: ptr_d = ptr_q + 21'h000001;
				TS_POST_DEC: ptr_d = ptr_q - 21'h000001;
				TS_PRE_INC:  ptr_d = ptr_q + 21'h000001;
				default:     ptr_d = ptr_q;
			endcase
		end
		if (wr_en) begin
			ptr_d = wr_data;
		end
	end

	// Registers the pointer state.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ptr_q <= RST_TPTR;
			acc_q <= RST_TPTR;
			stb_q <= 1'b0;
		end else begin
			ptr_q <= ptr_d;
			acc_q <= acc_d;
			stb_q <= stb_d;
		end
	end

	assign ptr        = ptr_q;
	assign acc_addr   = acc_q;
	assign acc_strobe = stb_q;

	// ====================================================================
	// Checks.
	property p_tbl_post_dec;
		@(posedge clk) disable iff (!rstn)
		(step_en && !wr_en && mode == TS_POST_DEC)
			|=> (ptr_q == $past(ptr_q) - 21'h000001) && (acc_q == $past(ptr_q)) && stb_q;
	endproperty
	a_tbl_post_dec: assert property (p_tbl_post_dec) else $error("post-decrement step wrong");

	property p_tbl_pre_inc;
		@(posedge clk) disable iff (!rstn)
		(step_en && !wr_en && mode == TS_PRE_INC)
			|=> (acc_q == $past(ptr_q) + 21'h000001) && (ptr_q == acc_q);
	endproperty
	a_tbl_pre_inc: assert property (p_tbl_pre_inc) else $error("pre-increment step wrong");

	property p_tbl_hold;
		@(posedge clk) disable iff (!rstn)
		(!wr_en && (!step_en || mode == TS_NONE)) |=> $stable(ptr_q);
	endproperty
	a_tbl_hold: assert property (p_tbl_hold) else $error("table pointer moved");

endmodule

// >>> hw/ofd_decoder.sv
// Purpose: Operand field decoder between instruction fetch and the datapath.
// Assumes: Fetch presents one word per valid cycle with its class; APB on clk.
// Notes:   Decoded fields appear one cycle after the last word is taken.
// Notes on behaviour
// - With the access bit clear the address lies in access RAM and the bank is unused.
// - With the access bit set the address is the bank register joined to the 8-bit field.
// - Bit instructions carry a three-bit position selecting bit 0 to 7.
// - A clear destination bit targets the accumulator, a set one the file register.
// - The file field is an 8-bit address or, for pointer loads, a 2-bit pointer select.
// - The two-word move takes a 12-bit source address from its first word.
// - The two-word move takes a 12-bit destination address from its second word.
// - Table accesses step the pointer not at all, after by +1 or -1, or before by +1.
// - The fast bit on call and return selects shadow register transfer.
// - A 21-bit table pointer addresses program memory.
// - Literals are 8, 12 or 20 bits wide depending on the instruction.
// - Branch fields are signed offsets for relative branches, absolute for call and goto.
// - Don't-care bits have no effect; encoders should leave them zero.
// - A 7-bit offset indexes the source location indirectly.
// - A 7-bit offset indexes the destination location indirectly.
// - A second word fetched on its own, top four bits ones, decodes as a no-operation.
`timescale 1ns/1ps
module ofd_decoder
	import ofd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ins_valid,
	input  wire logic [15:0] ins_word,
	input  wire ofd_cls_t    ins_class,
	output logic             dec_valid,
	output logic      [11:0] dec_data_addr,
	output logic      [2:0]  dec_bit_pos,
	output logic             dec_dest_file,
	output logic      [1:0]  dec_ptr_select,
	output logic      [19:0] dec_literal,
	output logic      [20:0] dec_target,
	output logic             dec_target_rel,
	output logic             dec_fast,
	output logic      [11:0] dec_src_addr,
	output logic      [11:0] dec_dst_addr,
	output logic      [6:0]  dec_src_off,
	output logic      [6:0]  dec_dst_off,
	output logic             dec_nop,
	output logic      [20:0] tbl_addr,
	output logic             tbl_strobe
);

	// ====================================================================
	// Fetch sequencer.
	ofd_fields_if fx ();
	ofd_state_t   st_q, st_d;
	logic [15:0]  word1_q, word1_d;
	ofd_cls_t     cls_q, cls_d;
	ofd_dec_t     dec_q, dec_d;
	logic         dval_q, dval_d;
	logic [3:0]   bank_q, bank_d;
	logic         stray, two_word, step_en;

	assign stray    = ins_word[POS_TAG_LO +: 4] == SECOND_TAG;
	assign two_word = (ins_class == CLS_MOVFF) || (ins_class == CLS_MOVSS) ||
	                  (ins_class == CLS_LFSR)  || (ins_class == CLS_CALL)  ||
	                  (ins_class == CLS_GOTO);

	// Feeds the field unit; in the second state the held first word is used.
	always_comb begin
		fx.bank  = bank_q;
		fx.word1 = (st_q == ST_SECOND) ? word1_q : ins_word;
		fx.word2 = (st_q == ST_SECOND) ? ins_word : 16'h0000;
		fx.cls   = (st_q == ST_SECOND) ? cls_q : ins_class;
	end

	ofd_field_unit u_fields (
		.f (fx.fld)
	);

	// Decides when a decode completes and what it publishes.
	always_comb begin
		st_d    = st_q;
		word1_d = word1_q;
		cls_d   = cls_q;
		dec_d   = dec_q;
		dval_d  = 1'b0;
		step_en = 1'b0;
		case (st_q)
			ST_FIRST: begin
				if (ins_valid && stray) begin
					dec_d     = '0;
					dec_d.nop = 1'b1;
					dval_d    = 1'b1;
				end else if (ins_valid && two_word) begin
					word1_d = ins_word;
					cls_d   = ins_class;
					st_d    = ST_SECOND;
				end else if (ins_valid) begin
					dec_d   = fx.dec;
					dval_d  = 1'b1;
					step_en = ins_class == CLS_TABLE;
				end
			end
			ST_SECOND: begin
				if (ins_valid) begin
					dec_d  = fx.dec;
					dval_d = 1'b1;
					st_d   = ST_FIRST;
				end
			end
			default: begin
				st_d = ST_FIRST;
			end
		endcase
	end

	// Registers the sequencer and the published fields.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q    <= ST_FIRST;
			word1_q <= 16'h0000;
			cls_q   <= CLS_BYTE;
			dec_q   <= '0;
			dval_q  <= 1'b0;
		end else begin
			st_q    <= st_d;
			word1_q <= word1_d;
			cls_q   <= cls_d;
			dec_q   <= dec_d;
			dval_q  <= dval_d;
		end
	end

	// ====================================================================
	// Table pointer.
	logic        tbl_wr;
	logic [20:0] tbl_ptr;

	ofd_table_ptr u_tbl (
		.clk        (clk),
		.rstn       (rstn),
		.wr_en      (tbl_wr),
		.wr_data    (pwdata[20:0]),
		.step_en    (step_en),
		.mode       (fx.dec.mode),
		.ptr        (tbl_ptr),
		.acc_addr   (tbl_addr),
		.acc_strobe (tbl_strobe)
	);

	// ====================================================================
	// APB slave, one wait state on every access.
	logic        ready_q, ready_d, err_q, err_d, acc_ph, done, mapped;
	logic [31:0] rdata_q, rdata_d, rmux;

	assign acc_ph = psel && penable;
	assign done   = acc_ph && ready_q;
	assign tbl_wr = done && pwrite && (paddr == OFS_TPTR);

	// Selects read data and flags unmapped addresses.
	always_comb begin
		rmux   = 32'h00000000;
		mapped = 1'b1;
		case (paddr)
			OFS_BANK:   rmux[3:0] = bank_q;
			OFS_TPTR:   rmux[20:0] = tbl_ptr;
			OFS_ADDR: begin
				rmux[RB_ADDR_LO +: 12] = dec_q.data_addr;
				rmux[RB_BIT_LO +: 3]   = dec_q.bit_pos;
				rmux[RB_DEST]          = dec_q.dest_file;
				rmux[RB_PSEL_LO +: 2]  = dec_q.ptr_select;
				rmux[RB_FAST]          = dec_q.fast;
				rmux[RB_MODE_LO +: 2]  = dec_q.mode;
				rmux[RB_NOP]           = dec_q.nop;
				rmux[RB_REL]           = dec_q.target_rel;
			end
			OFS_LIT:    rmux[19:0] = dec_q.lit;
			OFS_TARGET: rmux[20:0] = dec_q.target;
			OFS_MOVE: begin
				rmux[11:0]              = dec_q.src_addr;
				rmux[RB_DST_LO +: 12]   = dec_q.dst_addr;
			end
			OFS_OFFS: begin
				rmux[6:0]               = dec_q.src_off;
				rmux[RB_DOFF_LO +: 7]   = dec_q.dst_off;
			end
			OFS_STAT:   rmux[1:0] = st_q;
			default:    mapped = 1'b0;
		endcase
	end

	// Answers in the second access cycle; writes land at that edge.
	always_comb begin
		ready_d = acc_ph && !ready_q;
		rdata_d = rdata_q;
		err_d   = err_q;
		bank_d  = bank_q;
		if (acc_ph && !ready_q) begin
			rdata_d = pwrite ? 32'h00000000 : rmux;
			err_d   = !mapped;
		end
		if (done && pwrite && paddr == OFS_BANK) begin
			bank_d = pwdata[3:0];
		end
	end

	// Registers the bus answer and the bank register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ready_q <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h00000000;
			bank_q  <= RST_BANK;
		end else begin
			ready_q <= ready_d;
			err_q   <= err_d;
			rdata_q <= rdata_d;
			bank_q  <= bank_d;
		end
	end

	// Outputs straight from the registers.
	assign prdata         = rdata_q;
	assign pready         = ready_q;
	assign pslverr        = err_q;
	assign dec_valid      = dval_q;
	assign dec_data_addr  = dec_q.data_addr;
	assign dec_bit_pos    = dec_q.bit_pos;
	assign dec_dest_file  = dec_q.dest_file;
	assign dec_ptr_select = dec_q.ptr_select;
	assign dec_literal    = dec_q.lit;
	assign dec_target     = dec_q.target;
	assign dec_target_rel = dec_q.target_rel;
	assign dec_fast       = dec_q.fast;
	assign dec_src_addr   = dec_q.src_addr;
	assign dec_dst_addr   = dec_q.dst_addr;
	assign dec_src_off    = dec_q.src_off;
	assign dec_dst_off    = dec_q.dst_off;
	assign dec_nop        = dec_q.nop;

	// ====================================================================
	// Checks.
	sequence s_one(ofd_cls_t c);
		ins_valid && st_q == ST_FIRST && !stray && ins_class == c;
	endsequence

	sequence s_second(ofd_cls_t c);
		ins_valid && st_q == ST_SECOND && cls_q == c;
	endsequence

	property p_access_ram;
		@(posedge clk) disable iff (!rstn)
		(s_one(CLS_BYTE) ##0 !ins_word[POS_ACC]) |=> dval_q &&
			dec_q.data_addr[7:0] == $past(ins_word[7:0]) &&
			dec_q.data_addr[11:8] == (($past(ins_word[7:0]) < ACCESS_SPLIT) ?
			ACCESS_LO_BANK : ACCESS_HI_BANK);
	endproperty
	a_access_ram: assert property (p_access_ram) else $error("access RAM address wrong");

	property p_banked;
		@(posedge clk) disable iff (!rstn)
		(s_one(CLS_BIT) ##0 ins_word[POS_ACC])
			|=> dec_q.data_addr == {$past(bank_q), $past(ins_word[7:0])};
	endproperty
	a_banked: assert property (p_banked) else $error("banked address wrong");

	property p_bit_pos;
		@(posedge clk) disable iff (!rstn)
		s_one(CLS_BIT) |=> dval_q && dec_q.bit_pos == $past(ins_word[11:9]);
	endproperty
	a_bit_pos: assert property (p_bit_pos) else $error("bit position wrong");

	property p_dest;
		@(posedge clk) disable iff (!rstn)
		s_one(CLS_BYTE) |=> dec_q.dest_file == $past(ins_word[POS_DEST]);
	endproperty
	a_dest: assert property (p_dest) else $error("destination bit wrong");

	property p_move;
		@(posedge clk) disable iff (!rstn)
		s_one(CLS_MOVFF) ##1 s_second(CLS_MOVFF) |=> dval_q &&
			dec_q.src_addr == $past(word1_q[11:0]) && dec_q.dst_addr == $past(ins_word[11:0]);
	endproperty
	a_move: assert property (p_move) else $error("move addresses wrong");

	property p_move_wait;
		@(posedge clk) disable iff (!rstn)
		s_one(CLS_MOVFF) |=> st_q == ST_SECOND && !dval_q;
	endproperty
	a_move_wait: assert property (p_move_wait) else $error("first move word published");

	property p_offsets;
		@(posedge clk) disable iff (!rstn)
		s_second(CLS_MOVSS) |=> dec_q.src_off == $past(word1_q[6:0]) &&
			dec_q.dst_off == $past(ins_word[6:0]);
	endproperty
	a_offsets: assert property (p_offsets) else $error("indirect offsets wrong");

	property p_fast;
		@(posedge clk) disable iff (!rstn)
		s_one(CLS_RETURN) |=> dec_q.fast == $past(ins_word[POS_FAST]);
	endproperty
	a_fast: assert property (p_fast) else $error("fast bit wrong");

	property p_rel;
		@(posedge clk) disable iff (!rstn)
		s_one(CLS_BRA) |=> dec_q.target_rel &&
			dec_q.target == {{10{$past(ins_word[10])}}, $past(ins_word[10:0])};
	endproperty
	a_rel: assert property (p_rel) else $error("relative offset wrong");

	property p_stray;
		@(posedge clk) disable iff (!rstn)
		(ins_valid && st_q == ST_FIRST && stray) |=> dval_q && dec_nop && st_q == ST_FIRST;
	endproperty
	a_stray: assert property (p_stray) else $error("lone second word not a no-op");

endmodule

// >>> verification/ofd_fetch_model.sv
// Purpose: Fetch unit model that hands instruction words to the decoder.
// Assumes: Words of one instruction go out on consecutive clock edges.
// Notes:   Between words the bus shows the inverse of the last word.
`timescale 1ns/1ps
module ofd_fetch_model
	import ofd_pkg::*;
(
	input  wire logic        clk,
	output logic             ins_valid,
	output logic      [15:0] ins_word,
	output ofd_cls_t         ins_class
);
	// ====================================================================
	// Idle bus at time zero.
	initial begin
		ins_valid = 1'b0;
		ins_word  = 16'h0000;
		ins_class = CLS_BYTE;
	end

	// Issues one or two words, then releases the bus with a changed pattern.
	// Words are sent as the caller gives them, unused bits included.
	task automatic put(input logic [15:0] w1, input ofd_cls_t c, input logic two,
		input logic [15:0] w2);
		@(posedge clk);
		ins_valid <= 1'b1;
		ins_word  <= w1;
		ins_class <= c;
		if (two) begin
			@(posedge clk);
			ins_word  <= w2;
			ins_class <= ofd_cls_t'(~c);
		end
		@(posedge clk);
		ins_valid <= 1'b0;
		ins_word  <= two ? ~w2 : ~w1;
		ins_class <= ofd_cls_t'(~c);
	endtask
endmodule

// >>> verification/tb_opcode_field_decoder.sv
// Purpose: Self-checking bench of the opcode field decoder.
// Assumes: One wait state on APB, decode one cycle after the last word.
// Notes:   Expected fields are worked out here from the word layouts.
`timescale 1ns/1ps
module tb_opcode_field_decoder
	import ofd_pkg::*;
();
	// ====================================================================
	// Signals.
	logic        clk     = 1'b0;
	logic        rstn    = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h00000000;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, ins_valid, dec_valid, dec_dest_file;
	logic        dec_target_rel, dec_fast, dec_nop, tbl_strobe;
	logic [15:0] ins_word;
	ofd_cls_t    ins_class;
	logic [11:0] dec_data_addr, dec_src_addr, dec_dst_addr;
	logic [2:0]  dec_bit_pos;
	logic [1:0]  dec_ptr_select;
	logic [19:0] dec_literal;
	logic [20:0] dec_target, tbl_addr;
	logic [6:0]  dec_src_off, dec_dst_off;
	logic [9:0]  bcase [4] = '{10'h334, 10'h05F, 10'h260, 10'h080};
	int          n_mismatch = 0;
	int          cmp_count  = 0;

	// Clock of 100 MHz.
	always #5 clk = ~clk;

	// ====================================================================
	// Design and fetch model.
	ofd_decoder u_dut (
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ins_valid(ins_valid), .ins_word(ins_word),
		.ins_class(ins_class), .dec_valid(dec_valid), .dec_data_addr(dec_data_addr),
		.dec_bit_pos(dec_bit_pos), .dec_dest_file(dec_dest_file),
		.dec_ptr_select(dec_ptr_select), .dec_literal(dec_literal), .dec_target(dec_target),
		.dec_target_rel(dec_target_rel), .dec_fast(dec_fast),
		.dec_src_addr(dec_src_addr), .dec_dst_addr(dec_dst_addr),
		.dec_src_off(dec_src_off), .dec_dst_off(dec_dst_off), .dec_nop(dec_nop),
		.tbl_addr(tbl_addr), .tbl_strobe(tbl_strobe)
	);
	ofd_fetch_model u_fetch (
		.clk(clk), .ins_valid(ins_valid), .ins_word(ins_word), .ins_class(ins_class)
	);

	// ====================================================================
	// Tasks.
	// Prints the counts and the verdict, then stops.
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; holds the request until pready is seen at an edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1) begin
				break;
			end
			if (i == 15) begin
				n_mismatch++;
				print_verdict();
			end
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Sends an instruction and waits, bounded, for its decode pulse.
	task automatic dec(input logic [15:0] w1, input ofd_cls_t c, input logic two,
		input logic [15:0] w2);
		u_fetch.put(w1, c, two, w2);
		for (int i = 0; i < 8; i++) begin
			#1;
			if (dec_valid === 1'b1) begin
				break;
			end
			if (i == 7) begin
				n_mismatch++;
				print_verdict();
			end
			@(posedge clk);
		end
	endtask

	// ====================================================================
	// Main sequence.
	initial begin
		logic [9:0]  bc;
		logic [11:0] ea;
		logic [20:0] tp;
		logic [20:0] ta;
		logic [20:0] tn;
		ofd_step_t   md;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, OFS_TPTR, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, OFS_BANK, 32'h5);
		apb(1'b0, OFS_BANK, 32'h0);
		chk(rd, 32'h5);
		// Byte cases: banked, access RAM either side of the split.
		for (int i = 0; i < 4; i++) begin
			bc = bcase[i];
			ea = bc[8] ? {4'h5, bc[7:0]} : {(bc[7:0] < ACCESS_SPLIT) ? ACCESS_LO_BANK :
				ACCESS_HI_BANK, bc[7:0]};
			dec({6'h09, bc}, CLS_BYTE, 1'b0, 16'h0);
			chk(32'(dec_data_addr), 32'(ea));
			chk({31'h0, dec_dest_file}, {31'h0, bc[9]});
		end
		for (int b = 0; b < 8; b++) begin
			dec({4'h8, 3'(b), 1'b1, 8'h12}, CLS_BIT, 1'b0, 16'h0);
			chk(32'(dec_bit_pos), 32'(b));
		end
		// Literal with don't-care bits set.
		dec(16'h0FA5, CLS_LIT, 1'b0, 16'h0);
		chk(32'(dec_literal), 32'hA5);
		dec(16'hEE2A, CLS_LFSR, 1'b1, 16'hF0BC);
		chk(32'(dec_ptr_select), 32'h2);
		chk(32'(dec_literal), 32'hABC);
		dec(16'hCFFF, CLS_MOVFF, 1'b1, 16'hF801);
		chk(32'(dec_src_addr), 32'hFFF);
		chk(32'(dec_dst_addr), 32'h801);
		// Register readback of the move and of the sequencer state.
		apb(1'b0, OFS_MOVE, 32'h0);
		chk(rd, 32'h08010FFF);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd, 32'h1);
		// A lone second word decodes as a no-operation.
		dec(16'hF123, CLS_BYTE, 1'b0, 16'h0);
		chk({31'h0, dec_nop}, 32'h1);
		chk(32'(dec_src_addr), 32'h0);
		dec(16'hEBFF, CLS_MOVSS, 1'b1, 16'hF0C5);
		chk(32'(dec_src_off), 32'h7F);
		chk(32'(dec_dst_off), 32'h45);
		dec(16'hED34, CLS_CALL, 1'b1, 16'hFABC);
		chk(32'(dec_target), 32'h157868);
		chk({30'h0, dec_fast, dec_target_rel}, 32'h2);
		dec(16'hEF12, CLS_GOTO, 1'b1, 16'hF345);
		chk(32'(dec_target), 32'h068A24);
		for (int s = 0; s < 2; s++) begin
			dec({15'h0009, 1'(s)}, CLS_RETURN, 1'b0, 16'h0);
			chk({31'h0, dec_fast}, 32'(s));
		end
		dec(16'hD400, CLS_BRA, 1'b0, 16'h0);
		chk({10'h0, dec_target_rel, dec_target}, 32'h3FFC00);
		dec(16'hE080, CLS_BCOND, 1'b0, 16'h0);
		chk(32'(dec_target), 32'h1FFF80);
		// Table steps from the top of the pointer range, wrapping both ways.
		apb(1'b1, OFS_TPTR, 32'hFFFFFFFF);
		apb(1'b0, OFS_TPTR, 32'h0);
		chk(rd, 32'h1FFFFF);
		tp = 21'h1FFFFF;
		for (int m = 1; m < 5; m++) begin
			md = ofd_step_t'(m[1:0]);
			ta = (md == TS_PRE_INC) ? tp + 21'h1 : tp;
			tn = (md == TS_POST_DEC) ? tp - 21'h1 : (md == TS_NONE) ? tp : tp + 21'h1;
			dec({14'h0002, md}, CLS_TABLE, 1'b0, 16'h0);
			chk({31'h0, tbl_strobe}, 32'h1);
			chk(32'(tbl_addr), 32'(ta));
			apb(1'b0, OFS_TPTR, 32'h0);
			chk(rd, 32'(tn));
			tp = tn;
		end
		print_verdict();
	end
endmodule
